/* File: tip_defines.svh */
`ifndef TIP_DEFINES_SVH
`define TIP_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TIP_OFF_CTRL    8'h00
`define TIP_OFF_DATA    8'h04
`define TIP_OFF_COND    8'h08
`define TIP_OFF_TIME    8'h0C
`define TIP_OFF_TSTAMP  8'h10
`define TIP_OFF_STATUS  8'h14
`define TIP_OFF_CLKCFG  8'h20

// ****************************************
// control field positions and reset values
// ****************************************
`define TIP_CTRL_EN      0
`define TIP_CTRL_DIR     1
`define TIP_CTRL_OD      2
`define TIP_CTRL_CONDEN  3
`define TIP_CTRL_CONDNE  4
`define TIP_CTRL_STBEN   5
`define TIP_CTRL_CBSEL   8
`define TIP_CTRL_W       11
`define TIP_CTRL_RST     11'h000
`define TIP_CLKCFG_SRC   8
`define TIP_CLKCFG_W     9
`define TIP_CLKCFG_RST   9'h000

// ****************************************
// timing
// ****************************************
`define TIP_NUM_CB        6
`define TIP_REF_CLK_NS    50
`define TIP_CB0_MHZ       100
`define TIP_CB0_PERIOD_NS (1000 / `TIP_CB0_MHZ)
`define TIP_CB0_CYCLES    ((`TIP_CB0_PERIOD_NS / `TIP_REF_CLK_NS) < 1 ? \
                           1 : (`TIP_CB0_PERIOD_NS / `TIP_REF_CLK_NS))
`define TIP_CNT_W         16

`endif

/* File: tip_pkg.sv */
package tip_pkg;

  // ****************************************
  // control word, laid out as its register
  // ****************************************
  typedef struct packed {
    logic [2:0] cb_sel;
    logic [1:0] rsvd;
    logic       strobe_en;
    logic       cond_ne;
    logic       cond_en;
    logic       open_drain;
    logic       dir_out;
    logic       enable;
  } tip_ctrl_s;

  typedef struct packed {
    logic       src_ext;
    logic [7:0] div;
  } tip_clkcfg_s;

  typedef enum logic [1:0] {
    TIP_IDLE = 2'b00,
    TIP_WAIT = 2'b01,
    TIP_XFER = 2'b11
  } tip_state_e;

endpackage : tip_pkg

/* File: tip_fifo.sv */
`timescale 1ns/1ps
module tip_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= inc(rd_ptr);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tip_fifo

/* File: tip_clkblk.sv */
`timescale 1ns/1ps
`include "tip_defines.svh"
module tip_clkblk #(
  parameter bit IS_REF = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ext_edge,
  input  wire logic        src_ext,
  input  wire logic [7:0]  div,
  output logic             tick_out
);
  logic [7:0] cnt;
  logic [7:0] lim;
  logic       src_ev;

  // reference block counts the core clock only
  assign lim    = IS_REF ? 8'(`TIP_CB0_CYCLES - 1) : div;
  assign src_ev = (IS_REF || !src_ext) ? 1'b1 : ext_edge;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 8'h00;
      tick_out <= 1'b0;
    end else if (src_ev) begin
      if (cnt >= lim) begin
        cnt      <= 8'h00;
        tick_out <= 1'b1;
      end else begin
        cnt      <= cnt + 8'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule : tip_clkblk

/* File: tip_port.sv */
`timescale 1ns/1ps
`include "tip_defines.svh"
// Overview of operation
// - port has fixed width 1/4/8/16/32, all pins one direction
// - port drives pins or samples them, optionally awaiting a condition
// - each processor access completes in a single cycle, except a data access held back by fifo state or port direction
// - open-drain: zero drives low, one releases pin; per port
// - data passes through shift register and transfer register
// - 16-bit counter schedules pin/transfer-register moves
// - counter always readable; a future time delays next transfer
// - counter value captured as timestamp on every transfer
// - an enabled link sharing the pins disables the port
// - enabled narrower port takes shared pins from wider port
// - unshared pins of wider port stay usable
// - port always transfers at its full width
// - six clock blocks; block 0 is tile reference clock
// - blocks 1 to 5 each programmable to own rate
// - clock block may use 1-bit port clock, optionally divided
// - input strobe qualifies data; output strobe marks output data
// - after reset the port uses clock block 0
// - pin conditions raise events directly, no interrupt path
module tip_port #(
  parameter int W     = 8,
  parameter int DW    = 32,
  parameter int DEPTH = 16
) (
  input  wire logic          REF_CLK_IN,
  input  wire logic          RESET_N_IN,
  input  wire logic          PSEL_IN,
  input  wire logic          PENABLE_IN,
  input  wire logic          PWRITE_IN,
  input  wire logic [7:0]    PADDR_IN,
  input  wire logic [31:0]   PWDATA_IN,
  output logic      [31:0]   PRDATA_OUT,
  output logic               PREADY_OUT,
  output logic               PSLVERR_OUT,
  input  wire logic [W-1:0]  PIN_IN,
  output logic      [W-1:0]  PIN_OUT,
  output logic      [W-1:0]  PIN_OE_OUT,
  input  wire logic          READY_IN,
  output logic               OUTPUT_STROBE_OUT,
  input  wire logic          CLK_PIN_IN,
  input  wire logic          LINK_EN_IN,
  input  wire logic [W-1:0]  PIN_CLAIM_IN,
  output logic               EVENT_OUT
);
  localparam int NS = DW / W;
  localparam int SW = $clog2(NS + 1);
  localparam int CW = $clog2(DEPTH) + 1;

  // ****************************************
  // synchronisers
  // ****************************************
  logic [W-1:0] pin_s1;
  logic [W-1:0] pin_s2;
  logic         rdy_s1;
  logic         rdy_s2;
  logic         ck_s1;
  logic         ck_s2;
  logic         ck_s3;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      ck_s1  <= 1'b0;
      ck_s2  <= 1'b0;
      ck_s3  <= 1'b0;
    end else begin
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
      rdy_s1 <= READY_IN;
      rdy_s2 <= rdy_s1;
      ck_s1  <= CLK_PIN_IN;
      ck_s2  <= ck_s1;
      ck_s3  <= ck_s2;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  tip_pkg::tip_ctrl_s   ctrl;
  tip_pkg::tip_clkcfg_s cb_cfg [`TIP_NUM_CB];
  tip_pkg::tip_state_e  state;
  logic [W-1:0]         cond_val;
  logic [15:0]          target;
  logic                 armed;
  logic [15:0]          tstamp;
  logic [15:0]          cnt;
  logic [DW-1:0]        shreg;
  logic [DW-1:0]        xfer_word;
  logic                 xfer_valid;
  logic [SW-1:0]        slice;
  logic [W-1:0]         pin_q;

  // ****************************************
  // apb decode
  // ****************************************
  logic          acc;
  logic          done;
  logic          is_data;
  logic          en_port;
  logic          stall;
  logic          fifo_in_v;
  logic          fifo_in_r;
  logic [DW-1:0] fifo_in_d;
  logic          fifo_out_v;
  logic          fifo_out_r;
  logic [DW-1:0] fifo_out_d;
  logic [CW-1:0] fifo_cnt;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == `TIP_OFF_CTRL)   || (a == `TIP_OFF_DATA)  ||
          (a == `TIP_OFF_COND)   || (a == `TIP_OFF_TIME)  ||
          (a == `TIP_OFF_TSTAMP) || (a == `TIP_OFF_STATUS) ||
          (a >= `TIP_OFF_CLKCFG  &&
           a <  `TIP_OFF_CLKCFG + 8'(4 * `TIP_NUM_CB) &&
           a[1:0] == 2'b00);
  endfunction : hit

  function automatic int cb_idx(input logic [7:0] a);
    cb_idx = int'((a - `TIP_OFF_CLKCFG) >> 2);
  endfunction : cb_idx

  assign en_port = ctrl.enable & ~LINK_EN_IN;
  assign acc     = PSEL_IN & PENABLE_IN;
  assign is_data = (PADDR_IN == `TIP_OFF_DATA);
  // on an enabled port a data write waits for output mode with fifo room, a data read for input mode with fifo data
  assign stall   = acc & is_data & en_port &
                   (PWRITE_IN ? ~(ctrl.dir_out & fifo_in_r)
                              : ~(~ctrl.dir_out & fifo_out_v));
  assign PREADY_OUT  = ~stall;
  assign PSLVERR_OUT = acc & ~hit(PADDR_IN);
  assign done        = acc & PREADY_OUT;

  always_comb begin
    PRDATA_OUT = 32'h0000_0000;
    if (PSEL_IN && !PWRITE_IN) begin
      unique case (1'b1)
        PADDR_IN == `TIP_OFF_CTRL:
          PRDATA_OUT = 32'(ctrl);
        PADDR_IN == `TIP_OFF_DATA:
          PRDATA_OUT = (en_port & ~ctrl.dir_out) ? 32'(fifo_out_d)
                                                  : 32'h0000_0000;
        PADDR_IN == `TIP_OFF_COND:
          PRDATA_OUT = 32'(cond_val);
        PADDR_IN == `TIP_OFF_TIME:
          PRDATA_OUT = {16'h0000, cnt};
        PADDR_IN == `TIP_OFF_TSTAMP:
          PRDATA_OUT = {16'h0000, tstamp};
        PADDR_IN == `TIP_OFF_STATUS:
          PRDATA_OUT = {16'h0000, 8'(fifo_cnt), 1'b0, LINK_EN_IN,
                        armed, xfer_valid, 2'(state), fifo_in_r,
                        fifo_out_v};
        hit(PADDR_IN) && PADDR_IN >= `TIP_OFF_CLKCFG:
          PRDATA_OUT = 32'(cb_cfg[cb_idx(PADDR_IN)]);
        default:
          PRDATA_OUT = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl     <= tip_pkg::tip_ctrl_s'(`TIP_CTRL_RST);
      cond_val <= '0;
    end else if (done && PWRITE_IN) begin
      if (PADDR_IN == `TIP_OFF_CTRL) begin
        ctrl <= tip_pkg::tip_ctrl_s'(PWDATA_IN[`TIP_CTRL_W-1:0]);
      end
      if (PADDR_IN == `TIP_OFF_COND) begin
        cond_val <= PWDATA_IN[W-1:0];
      end
    end
  end

  // block 0 is fixed to the reference clock
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int i = 0; i < `TIP_NUM_CB; i++) begin
        cb_cfg[i] <= tip_pkg::tip_clkcfg_s'(`TIP_CLKCFG_RST);
      end
    end else if (done && PWRITE_IN && hit(PADDR_IN) &&
                 PADDR_IN >= `TIP_OFF_CLKCFG + 8'h04) begin
      cb_cfg[cb_idx(PADDR_IN)] <=
        tip_pkg::tip_clkcfg_s'(PWDATA_IN[`TIP_CLKCFG_W-1:0]);
    end
  end

  // ****************************************
  // clock blocks
  // ****************************************
  logic [`TIP_NUM_CB-1:0] cb_tick;
  logic                   tick;

  for (genvar g = 0; g < `TIP_NUM_CB; g++) begin : g_cb
    tip_clkblk #(
      .IS_REF   (g == 0)
    ) u_cb (
      .clk      (REF_CLK_IN),
      .rst_n    (RESET_N_IN),
      .ext_edge (ck_s2 & ~ck_s3),
      .src_ext  (cb_cfg[g].src_ext),
      .div      (cb_cfg[g].div),
      .tick_out (cb_tick[g])
    );
  end

  // unused selector codes fall back to the reference block
  assign tick = (ctrl.cb_sel < 3'(`TIP_NUM_CB)) ? cb_tick[ctrl.cb_sel]
                                                : cb_tick[0];

  // ****************************************
  // port counter and timed start
  // ****************************************
  logic tm_ok;
  logic smp_ok;
  logic cond_ok;
  logic start;
  logic step;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cnt <= 16'h0000;
    end else if (tick) begin
      cnt <= cnt + 16'h0001;
    end
  end

  assign tm_ok   = ~armed | (cnt == target);
  assign smp_ok  = ctrl.dir_out | ~ctrl.strobe_en | rdy_s2;
  assign cond_ok = ctrl.dir_out | ~ctrl.cond_en |
                   ((pin_s2 == cond_val) ^ ctrl.cond_ne);
  assign start   = tick & (state == tip_pkg::TIP_WAIT) &
                   tm_ok & smp_ok & cond_ok;
  // last slice ends the word: no extra shift or strobe
  assign step    = tick & (state == tip_pkg::TIP_XFER) & smp_ok &
                   (slice != SW'(NS));

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      target <= 16'h0000;
      armed  <= 1'b0;
    end else if (done && PWRITE_IN && PADDR_IN == `TIP_OFF_TIME) begin
      target <= PWDATA_IN[15:0];
      armed  <= 1'b1;
    end else if (start) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tstamp <= 16'h0000;
    end else if (start) begin
      tstamp <= cnt;
    end
  end

  // ****************************************
  // serialiser engine
  // ****************************************
  function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] s,
                                             input logic [W-1:0] p);
    logic [DW+W-1:0] t;
    t        = {p, s} >> W;
    shift_in = t[DW-1:0];
  endfunction : shift_in

  logic xfer_take;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= tip_pkg::TIP_IDLE;
      shreg <= '0;
      slice <= '0;
    end else if (!en_port) begin
      state <= tip_pkg::TIP_IDLE;
      slice <= '0;
    end else begin
      unique case (state)
        tip_pkg::TIP_IDLE: begin
          if (!ctrl.dir_out || xfer_valid) begin
            if (ctrl.dir_out) begin
              shreg <= xfer_word;
            end
            state <= tip_pkg::TIP_WAIT;
          end
        end
        tip_pkg::TIP_WAIT: begin
          if (start) begin
            shreg <= ctrl.dir_out ? (shreg >> W)
                                  : shift_in(shreg, pin_s2);
            slice <= SW'(1);
            state <= tip_pkg::TIP_XFER;
          end
        end
        tip_pkg::TIP_XFER: begin
          if (slice == SW'(NS)) begin
            if (ctrl.dir_out || !xfer_valid) begin
              slice <= '0;
              state <= tip_pkg::TIP_IDLE;
            end
          end else if (step) begin
            shreg <= ctrl.dir_out ? (shreg >> W)
                                  : shift_in(shreg, pin_s2);
            slice <= slice + SW'(1);
          end
        end
        default: begin
          state <= tip_pkg::TIP_IDLE;
        end
      endcase
    end
  end

  // transfer register between fifo and shift register
  assign xfer_take = ctrl.dir_out
    ? (state == tip_pkg::TIP_IDLE) & en_port & xfer_valid
    : (state == tip_pkg::TIP_XFER) & (slice == SW'(NS)) & ~xfer_valid;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      xfer_word  <= '0;
      xfer_valid <= 1'b0;
    end else if (ctrl.dir_out) begin
      if (xfer_take) begin
        xfer_valid <= 1'b0;
      end else if (!xfer_valid && fifo_out_v) begin
        xfer_word  <= fifo_out_d;
        xfer_valid <= 1'b1;
      end
    end else begin
      if (xfer_take) begin
        xfer_word  <= shreg;
        xfer_valid <= 1'b1;
      end else if (fifo_in_r) begin
        xfer_valid <= 1'b0;
      end
    end
  end

  // ****************************************
  // fifo
  // ****************************************
  assign fifo_in_v  = ctrl.dir_out
                      ? done & PWRITE_IN & is_data & en_port
                      : xfer_valid;
  assign fifo_in_d  = ctrl.dir_out ? PWDATA_IN[DW-1:0] : xfer_word;
  assign fifo_out_r = ctrl.dir_out
                      ? ~xfer_valid
                      : done & ~PWRITE_IN & is_data & en_port;

  tip_fifo #(
    .WIDTH     (DW),
    .DEPTH     (DEPTH)
  ) u_fifo (
    .clk       (REF_CLK_IN),
    .rst_n     (RESET_N_IN),
    .in_valid  (fifo_in_v),
    .in_ready  (fifo_in_r),
    .in_data   (fifo_in_d),
    .out_valid (fifo_out_v),
    .out_ready (fifo_out_r),
    .out_data  (fifo_out_d),
    .count     (fifo_cnt)
  );

  // ****************************************
  // pins, strobe and events
  // ****************************************
  logic drive;

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_q             <= '0;
      OUTPUT_STROBE_OUT <= 1'b0;
    end else if (tick) begin
      if (ctrl.dir_out && en_port && (start || step)) begin
        pin_q             <= shreg[W-1:0];
        OUTPUT_STROBE_OUT <= ctrl.strobe_en;
      end else begin
        OUTPUT_STROBE_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      EVENT_OUT <= 1'b0;
    end else begin
      EVENT_OUT <= (start & ~ctrl.dir_out & ctrl.cond_en) |
                   (xfer_take & ~ctrl.dir_out);
    end
  end

  // one direction for the whole port
  assign drive   = en_port & ctrl.dir_out;
  assign PIN_OUT = ctrl.open_drain ? '0 : pin_q;

  always_comb begin
    for (int b = 0; b < W; b++) begin
      PIN_OE_OUT[b] = drive & ~PIN_CLAIM_IN[b] &
                      (~ctrl.open_drain | ~pin_q[b]);
    end
  end
endmodule : tip_port

/* File: tip_port_chk.sv */
`timescale 1ns/1ps
`include "tip_defines.svh"
// ****
// port-side checks
// ****
module tip_port_chk #(
  parameter int W = 8
) (
  input wire logic         REF_CLK_IN,
  input wire logic         RESET_N_IN,
  input wire logic         PSEL_IN,
  input wire logic         PENABLE_IN,
  input wire logic         PWRITE_IN,
  input wire logic [7:0]   PADDR_IN,
  input wire logic [31:0]  PRDATA_OUT,
  input wire logic         PREADY_OUT,
  input wire logic         PSLVERR_OUT,
  input wire logic [W-1:0] PIN_OE_OUT,
  input wire logic         OUTPUT_STROBE_OUT,
  input wire logic         LINK_EN_IN,
  input wire logic [W-1:0] PIN_CLAIM_IN,
  input wire logic         EVENT_OUT
);
  logic mapped;
  assign mapped = (PADDR_IN[1:0] == 2'h0) &&
                  ((PADDR_IN <= 8'h14) ||
                   (PADDR_IN >= 8'h20 && PADDR_IN <= 8'h34));
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence
  sequence s_link_held;
    LINK_EN_IN [*3];
  endsequence
  a_zero_wait: assert property (
    (s_access ##0 (PADDR_IN != `TIP_OFF_DATA)) |-> PREADY_OUT)
    else $error("access stalled off the data register");
  a_err_unmapped: assert property (
    (s_access ##0 !mapped) |-> PSLVERR_OUT && PREADY_OUT)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (
    (s_access ##0 mapped) |-> !PSLVERR_OUT)
    else $error("mapped access refused");
  a_rdata_unmapped: assert property (
    (s_access ##0 (!mapped && !PWRITE_IN)) |-> PRDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_claim_oe: assert property (
    PIN_CLAIM_IN != '0 |-> (PIN_OE_OUT & PIN_CLAIM_IN) == '0)
    else $error("claimed pin still driven");
  a_link_oe: assert property (
    s_link_held |-> PIN_OE_OUT == '0)
    else $error("pins driven under link");
  a_link_quiet: assert property (
    s_link_held |-> !OUTPUT_STROBE_OUT && !EVENT_OUT)
    else $error("port active under link");
  a_event_pulse: assert property (
    EVENT_OUT |=> !EVENT_OUT)
    else $error("event longer than one cycle");
  a_reset_quiet: assert property (
    $rose(RESET_N_IN) |-> !OUTPUT_STROBE_OUT && PIN_OE_OUT == '0)
    else $error("outputs active after reset");
endmodule : tip_port_chk

/* File: tip_ext_model.sv */
`timescale 1ns/1ps
// ****
// pin-side hardware
// ****
module tip_ext_model #(
  parameter int W = 8
) (
  input  wire logic         clk_run_in,
  input  wire logic         drive_en_in,
  input  wire logic [W-1:0] drive_val_in,
  input  wire logic         ready_cmd_in,
  input  wire logic [W-1:0] pin_out_in,
  input  wire logic [W-1:0] pin_oe_in,
  output logic      [W-1:0] wire_out,
  output logic              ready_out,
  output logic              ext_clk_out
);
  // released pins float to the pull-up unless drive_en_in drives them with drive_val_in
  always_comb begin
    for (int i = 0; i < W; i++) begin
      wire_out[i] = pin_oe_in[i] ? pin_out_in[i]
                  : (drive_en_in ? drive_val_in[i] : 1'b1);
    end
  end
  // strobe only together with driven data
  assign ready_out = drive_en_in & ready_cmd_in;
  // application clock stands still unless running
  logic ck = 1'b0;
  always #35 ck = clk_run_in ? ~ck : 1'b0;
  assign ext_clk_out = ck;
endmodule : tip_ext_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "tip_defines.svh"
module testbench;
  localparam int          W     = 8;
  localparam logic [31:0] C_OUT = 32'h0000_0023;
  localparam logic [31:0] C_OD  = 32'h0000_0027;
  localparam logic [31:0] C_IN  = 32'h0000_0029;
  logic        clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, a, v;
  logic [W-1:0] pin_out, pin_oe, claim, drv_val, wire_lvl;
  logic        rdy_cmd, drv_en, run, ready_in, strobe, ext_clk, link, ev;
  int          bad_count, compares, cyc, seed, tk, t1, first_cyc, evs, ts_cyc;
  logic [W-1:0] exp_q[$];
  always #25 clk = ~clk;
  tip_port dut_u (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .PIN_IN(wire_lvl), .PIN_OUT(pin_out),
    .PIN_OE_OUT(pin_oe), .READY_IN(ready_in), .OUTPUT_STROBE_OUT(strobe),
    .CLK_PIN_IN(ext_clk), .LINK_EN_IN(link), .PIN_CLAIM_IN(claim),
    .EVENT_OUT(ev));
  tip_ext_model #(.W(W)) ext_u (.clk_run_in(run), .drive_en_in(drv_en),
    .drive_val_in(drv_val), .ready_cmd_in(rdy_cmd), .pin_out_in(pin_out),
    .pin_oe_in(pin_oe), .wire_out(wire_lvl), .ready_out(ready_in),
    .ext_clk_out(ext_clk));
  // ****
  // helpers
  // ****
  task automatic close_out();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    q = prdata; err = pslverr; tk = cyc;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 3000) begin
      bad_count++;
      close_out();
    end
  endtask : apb
  task automatic send(input logic [31:0] w, input logic [W-1:0] m);
    for (int i = 0; i < 32 / W; i++) exp_q.push_back(w[i*W +: W] | m);
    apb(1'b1, `TIP_OFF_DATA, w);
  endtask : send
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(exp_q.size()), 32'h0);
  endtask : drain
  // ****
  // slice monitor and timeout
  // ****
  always @(posedge clk) begin
    if (strobe === 1'b1) begin
      if (first_cyc == 0) first_cyc = cyc;
      if (exp_q.size() % (32 / W) == 0) ts_cyc = cyc;
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(32'(wire_lvl), 32'(exp_q.pop_front()));
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    seed = 39; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; claim = '0; drv_val = '0;
    rdy_cmd = 1'b0; drv_en = 1'b0; run = 1'b0; link = 1'b0;
    bad_count = 0; compares = 0; cyc = 0; first_cyc = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `TIP_OFF_CTRL, 32'h0); chk(q, 32'h0);
    apb(1'b0, 8'h18, 32'h0); chk({q[31:1], ~err}, 32'h0);
    apb(1'b1, `TIP_OFF_CTRL, 32'h0000_0003);
    apb(1'b0, `TIP_OFF_TIME, 32'h0); a = q; t1 = tk;
    repeat (7) @(posedge clk);
    apb(1'b0, `TIP_OFF_TIME, 32'h0);
    chk(32'(q[15:0] - a[15:0]), 32'(16'(tk - t1)));
    apb(1'b1, 8'h24, 32'h0000_0100);
    apb(1'b0, 8'h24, 32'h0); chk(q, 32'h0000_0100);
    apb(1'b1, `TIP_OFF_CLKCFG, 32'h0000_01FF);
    apb(1'b0, `TIP_OFF_CLKCFG, 32'h0); chk(q, 32'h0);
    apb(1'b1, `TIP_OFF_CTRL, 32'h0000_0103);
    apb(1'b0, `TIP_OFF_TIME, 32'h0); a = q;
    repeat (10) @(posedge clk);
    apb(1'b0, `TIP_OFF_TIME, 32'h0); chk(q, a);
    run <= 1'b1;
    repeat (40) @(posedge clk);
    run <= 1'b0;
    apb(1'b0, `TIP_OFF_TIME, 32'h0); chk(32'(q != a), 32'h1);
    apb(1'b1, `TIP_OFF_CTRL, C_OUT);
    send($random(seed), '0);
    send($random(seed), '0);
    drain();
    claim <= 8'h0F;
    send($random(seed), 8'h0F);
    drain();
    claim <= '0;
    apb(1'b1, `TIP_OFF_CTRL, C_OD);
    send($random(seed), '0);
    drain();
    apb(1'b1, `TIP_OFF_CTRL, C_OUT);
    apb(1'b0, `TIP_OFF_TIME, 32'h0); v = q; t1 = tk; first_cyc = 0;
    apb(1'b1, `TIP_OFF_TIME, 32'(v[15:0] + 16'd300));
    for (int k = 0; k < 24; k++) begin
      send($random(seed), '0);
      apb(1'b0, `TIP_OFF_STATUS, 32'h0);
      if (q[1] === 1'b0) break;
    end
    chk(32'(q[15:8]), 32'd16);
    send($random(seed), '0);
    drain();
    chk(32'(first_cyc - t1 >= 300 && first_cyc - t1 <= 304), 32'h1);
    apb(1'b0, `TIP_OFF_TSTAMP, 32'h0);
    a = 32'(16'(q[15:0] - v[15:0]));
    chk(a, 32'(16'(ts_cyc - 1 - t1)));
    apb(1'b0, `TIP_OFF_STATUS, 32'h0); chk(32'(q[0]), 32'h0);
    apb(1'b1, `TIP_OFF_COND, 32'h0000_00A5);
    apb(1'b1, `TIP_OFF_CTRL, C_IN);
    drv_en <= 1'b1;
    for (int ph = 0; ph < 3; ph++) begin
      rdy_cmd <= (ph != 0);
      drv_val <= (ph == 1) ? 8'h5A : 8'hA5;
      evs = 0;
      repeat (30) begin
        @(posedge clk);
        if (ev === 1'b1) evs++;
      end
      chk(32'(evs != 0), 32'(ph == 2));
    end
    apb(1'b0, `TIP_OFF_DATA, 32'h0); chk(q, 32'hA5A5_A5A5);
    chk(32'(pin_oe), 32'h0);
    drv_en <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `TIP_OFF_CTRL, 32'h0); chk(q, 32'h0);
    apb(1'b1, `TIP_OFF_CTRL, C_OUT);
    link <= 1'b1;
    apb(1'b1, `TIP_OFF_DATA, $random(seed));
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h40, 32'h0); chk(32'(err), 32'h1);
    close_out();
  end
endmodule : testbench
bind tip_port tip_port_chk #(.W(W)) chk_u (.REF_CLK_IN(REF_CLK_IN),
  .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .PIN_OE_OUT(PIN_OE_OUT), .OUTPUT_STROBE_OUT(OUTPUT_STROBE_OUT),
  .LINK_EN_IN(LINK_EN_IN), .PIN_CLAIM_IN(PIN_CLAIM_IN),
  .EVENT_OUT(EVENT_OUT));
